// >>> lsd_pkg.sv
package lsd_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int SEG_LINES       = 30;
	localparam int DOTS            = 60;
	localparam int NIBBLES         = 15;
	localparam int GROUPS          = 8;
	localparam int GROUP_DOTS      = 7;
	localparam int LAST_GROUP_DOTS = 4;
	localparam int SCAN_PINS       = 16;
	localparam int KEY_INPUTS      = 4;

	// Port group pin ranges (lowest pin of each)
	localparam int GRP_SCAN_LO = 0;
	localparam int GRP_C_LO    = 16;
	localparam int GRP_B_LO    = 22;
	localparam int GRP_A_LO    = 26;

	// ----------------------------------------------------------------
	// Register addresses and fields
	// ----------------------------------------------------------------
	localparam logic [6:0] RF_MODE_ADDR   = 7'h10;
	localparam logic [6:0] RF_PORT_ADDR   = 7'h11;
	localparam logic [7:0] PB_GROUP_BASE  = 8'h08;
	localparam logic [7:0] PB_GROUP_LAST  = 8'h0f;
	localparam logic [7:0] PB_SCAN_ADDR   = 8'h42;
	localparam int         MODE_DISP_BIT  = 0;
	localparam int         MODE_SCAN_BIT  = 1;
	localparam int         PSEL_SCAN_BIT  = 0;
	localparam int         PSEL_C_BIT     = 1;
	localparam int         PSEL_B_BIT     = 2;
	localparam int         PSEL_A_BIT     = 3;
	localparam logic [3:0] MODE_RESET     = 4'h0;
	localparam logic [3:0] PSEL_RESET     = 4'h0;
	localparam logic [15:0] SCAN_RESET    = 16'h0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS       = 1000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int SLOT_US       = 2000;
	localparam int SCAN_US       = 100;

	// ----------------------------------------------------------------
	// Common line drive levels
	// ----------------------------------------------------------------
	localparam logic [1:0] LVL_LOW  = 2'h0;
	localparam logic [1:0] LVL_MID  = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	typedef enum logic [1:0] {
		LSD_OFF  = 2'b00,
		LSD_SCAN = 2'b01,
		LSD_DISP = 2'b10
	} lsd_fsm_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [3:0] wdata;
	} lsd_dm_req_s;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [3:0] wdata;
	} lsd_rf_req_s;

	typedef struct packed {
		logic        put;
		logic        get;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} lsd_pb_req_s;

endpackage

// >>> lsd_seg_mem.sv
`timescale 1ns/1ps
module lsd_seg_mem
	import lsd_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic [DOTS-1:0]   wr_mask,
	input  wire logic [DOTS-1:0]   wr_bits,
	input  wire logic [3:0]        rd_idx,
	output logic      [3:0]        rd_nib,
	output logic      [DOTS-1:0]   bits
);

	typedef struct packed {
		logic [DOTS-1:0] bits;
		logic [3:0]      rd_nib;
	} lsd_mem_s;

	lsd_mem_s mem_reg;
	lsd_mem_s mem_next;

	always_comb
	begin
		mem_next      = mem_reg;
		mem_next.bits = (mem_reg.bits & ~wr_mask) | (wr_bits & wr_mask);
		if (int'(rd_idx) < NIBBLES)
		begin
			mem_next.rd_nib = mem_reg.bits[rd_idx*4 +: 4];
		end
		else
		begin
			mem_next.rd_nib = 4'h0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			mem_reg <= '0;
		end
		else
		begin
			mem_reg <= mem_next;
		end
	end

	assign rd_nib = mem_reg.rd_nib;
	assign bits   = mem_reg.bits;

endmodule

// >>> lsd_driver.sv
// Functional notes
// - Drive up to 60 dots, two commons
// - Each segment line controls two dots
// - Half duty, half bias drive waveform
// - Four independently switchable port groups
// - Lowest sixteen pins output key-scan signals
// - Memory bit one lights, zero darkens
// - Each nibble holds four dots
// - Segment memory plainly read and written
// - Group registers load only from buffer
// - Group write updates segment memory bits
// - Port pins drive their memory bit; scan-group port pins drive scan data
// - Commons low when display is off
// - Segments low when display is off, except pins of groups switched to port use
// - Mode register at 10H enables display
// - Mode register enables key-scan output
// - Port-select register at 11H picks use
// - Scan data register at 42H
// - Group writes carry seven or four dots
// - Group register reads return zero
`timescale 1ns/1ps
module lsd_driver
	import lsd_pkg::*;
#(
	parameter int unsigned SLOT_LEN_US = SLOT_US,
	parameter int unsigned SCAN_LEN_US = SCAN_US
)
(
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire lsd_dm_req_s           dm_req,
	output logic      [3:0]            dm_rdata,
	input  wire lsd_rf_req_s           rf_req,
	output logic      [3:0]            rf_rdata,
	input  wire lsd_pb_req_s           pb_req,
	output logic      [15:0]           pb_rdata,
	input  wire logic [KEY_INPUTS-1:0] key_return_inputs,
	output logic      [KEY_INPUTS-1:0] key_sample,
	output logic                       key_sample_valid,
	output logic                       scan_active,
	output logic      [1:0]            common_line_low,
	output logic      [1:0]            common_line_high,
	output logic      [SEG_LINES-1:0]  segment_pins
);

	typedef struct packed {
		lsd_fsm_e              fsm;
		logic                  slot;
		logic                  polarity;
		logic [7:0]            tick_cnt;
		logic [15:0]           us_cnt;
		logic [3:0]            mode;
		logic [3:0]            port_sel;
		logic [15:0]           scan_data;
		logic [3:0]            rf_rdata;
		logic [15:0]           pb_rdata;
		logic [1:0]            com_low;
		logic [1:0]            com_high;
		logic [SEG_LINES-1:0]  seg;
		logic [KEY_INPUTS-1:0] key_meta;
		logic [KEY_INPUTS-1:0] key_sync;
		logic [KEY_INPUTS-1:0] key_sample;
		logic                  key_valid;
		logic                  scan_active;
	} lsd_state_s;

	lsd_state_s st_reg;
	lsd_state_s st_next;

	logic [DOTS-1:0] mem_bits;
	logic [DOTS-1:0] wr_mask;
	logic [DOTS-1:0] wr_bits;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// Port-select bit that governs a segment pin
	function automatic int pin_psel_bit(input int pin);
		if (pin >= GRP_A_LO)
		begin
			return PSEL_A_BIT;
		end
		else if (pin >= GRP_B_LO)
		begin
			return PSEL_B_BIT;
		end
		else if (pin >= GRP_C_LO)
		begin
			return PSEL_C_BIT;
		end
		return PSEL_SCAN_BIT;
	endfunction

	// Dot mask for a group register
	function automatic logic [DOTS-1:0] group_mask(input logic [2:0] grp);
		logic [DOTS-1:0] m;
		m = '0;
		for (int i = 0; i < GROUP_DOTS; i++)
		begin
			if ((grp != 3'(GROUPS - 1)) || (i < LAST_GROUP_DOTS))
			begin
				m[int'(grp) * GROUP_DOTS + i] = 1'b1;
			end
		end
		return m;
	endfunction

	function automatic logic is_group_addr(input logic [7:0] addr);
		return (addr >= PB_GROUP_BASE) && (addr <= PB_GROUP_LAST);
	endfunction

	// ----------------------------------------------------------------
	// Segment memory write path
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [2:0] grp;
		logic [DOTS-1:0] gmask;
		grp     = 3'(pb_req.addr - PB_GROUP_BASE);
		gmask   = group_mask(grp);
		wr_mask = '0;
		wr_bits = '0;
		if (dm_req.wr && (int'(dm_req.addr) < NIBBLES))
		begin
			wr_mask[dm_req.addr*4 +: 4] = 4'hf;
			wr_bits[dm_req.addr*4 +: 4] = dm_req.wdata;
		end
		// Group transfer wins over a same-cycle nibble write
		if (pb_req.put && is_group_addr(pb_req.addr))
		begin
			wr_mask = (wr_mask & ~gmask) | gmask;
			wr_bits = (wr_bits & ~gmask)
				| (DOTS'(pb_req.wdata[GROUP_DOTS-1:0]) << (int'(grp) * GROUP_DOTS) & gmask);
		end
	end

	lsd_seg_mem u_seg_mem
	(
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr_mask (wr_mask),
		.wr_bits (wr_bits),
		.rd_idx  (dm_req.addr),
		.rd_nib  (dm_rdata),
		.bits    (mem_bits)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic tick;
		logic disp_on;
		logic scan_on;
		logic slot_done;
		logic scan_done;
		logic dot;
		st_next = st_reg;
		dot     = 1'b0;
		tick    = (st_reg.tick_cnt == 8'(TICK_CYCLES - 1));
		disp_on = st_reg.mode[MODE_DISP_BIT];
		scan_on = st_reg.mode[MODE_SCAN_BIT];
		slot_done = tick && (st_reg.us_cnt == 16'(SLOT_LEN_US - 1));
		scan_done = tick && (st_reg.us_cnt == 16'(SCAN_LEN_US - 1));
		st_next.key_valid = 1'b0;

		// Key return synchroniser
		st_next.key_meta = key_return_inputs;
		st_next.key_sync = st_reg.key_meta;

		// Microsecond enable divider
		st_next.tick_cnt = tick ? 8'h00 : st_reg.tick_cnt + 8'h01;
		if (tick)
		begin
			st_next.us_cnt = st_reg.us_cnt + 16'h0001;
		end

		// Control file access
		if (rf_req.wr && (rf_req.addr == RF_MODE_ADDR))
		begin
			st_next.mode = rf_req.wdata;
		end
		if (rf_req.wr && (rf_req.addr == RF_PORT_ADDR))
		begin
			st_next.port_sel = rf_req.wdata;
		end
		if (rf_req.rd)
		begin
			unique case (rf_req.addr)
				RF_MODE_ADDR: st_next.rf_rdata = st_reg.mode;
				RF_PORT_ADDR: st_next.rf_rdata = st_reg.port_sel;
				default:      st_next.rf_rdata = 4'h0;
			endcase
		end

		// Peripheral transfers through the buffer
		if (pb_req.put && (pb_req.addr == PB_SCAN_ADDR))
		begin
			st_next.scan_data = pb_req.wdata;
		end
		if (pb_req.get)
		begin
			// Group registers give no data back
			st_next.pb_rdata = (pb_req.addr == PB_SCAN_ADDR) ? st_reg.scan_data : 16'h0000;
		end

		// ------------------------------------------------------------
		// Slot sequencer
		// ------------------------------------------------------------
		unique case (st_reg.fsm)
			LSD_OFF:
			begin
				if (disp_on)
				begin
					st_next.fsm    = scan_on ? LSD_SCAN : LSD_DISP;
					st_next.slot   = 1'b0;
					st_next.us_cnt = 16'h0000;
				end
			end
			LSD_SCAN:
			begin
				if (scan_done)
				begin
					st_next.fsm        = LSD_DISP;
					st_next.us_cnt     = 16'h0000;
					st_next.key_sample = st_reg.key_sync;
					st_next.key_valid  = 1'b1;
				end
			end
			LSD_DISP:
			begin
				if (slot_done)
				begin
					st_next.fsm    = scan_on ? LSD_SCAN : LSD_DISP;
					st_next.slot   = ~st_reg.slot;
					st_next.us_cnt = 16'h0000;
					if (st_reg.slot)
					begin
						st_next.polarity = ~st_reg.polarity;
					end
				end
			end
			default:
			begin
				st_next.fsm = LSD_OFF;
			end
		endcase
		if (!disp_on)
		begin
			st_next.fsm      = LSD_OFF;
			st_next.polarity = 1'b0;
		end

		// ------------------------------------------------------------
		// Pin drive
		// ------------------------------------------------------------
		st_next.scan_active = (st_reg.fsm == LSD_SCAN);
		if (st_reg.fsm == LSD_OFF)
		begin
			st_next.com_low  = LVL_LOW;
			st_next.com_high = LVL_LOW;
		end
		else if (st_reg.fsm == LSD_SCAN)
		begin
			st_next.com_low  = LVL_MID;
			st_next.com_high = LVL_MID;
		end
		else
		begin
			// Selected common swings, the other rests at mid level
			st_next.com_low  = st_reg.slot ? LVL_MID : (st_reg.polarity ? LVL_HIGH : LVL_LOW);
			st_next.com_high = st_reg.slot ? (st_reg.polarity ? LVL_HIGH : LVL_LOW) : LVL_MID;
		end
		for (int k = 0; k < SEG_LINES; k++)
		begin
			dot = mem_bits[2*k + int'(st_reg.slot)];
			if (st_reg.port_sel[pin_psel_bit(k)])
			begin
				st_next.seg[k] = (k < SCAN_PINS) ? st_reg.scan_data[k[3:0]] : mem_bits[2*k];
			end
			else if (st_reg.fsm == LSD_OFF)
			begin
				st_next.seg[k] = 1'b0;
			end
			else if ((st_reg.fsm == LSD_SCAN) && (k < SCAN_PINS))
			begin
				st_next.seg[k] = st_reg.scan_data[k[3:0]];
			end
			else
			begin
				// Lit dot opposes the selected common
				st_next.seg[k] = st_reg.polarity ^ dot;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			st_reg           <= '0;
			st_reg.fsm       <= LSD_OFF;
			st_reg.mode      <= MODE_RESET;
			st_reg.port_sel  <= PSEL_RESET;
			st_reg.scan_data <= SCAN_RESET;
			st_reg.com_low   <= LVL_LOW;
			st_reg.com_high  <= LVL_LOW;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign rf_rdata         = st_reg.rf_rdata;
	assign pb_rdata         = st_reg.pb_rdata;
	assign key_sample       = st_reg.key_sample;
	assign key_sample_valid = st_reg.key_valid;
	assign scan_active      = st_reg.scan_active;
	assign common_line_low  = st_reg.com_low;
	assign common_line_high = st_reg.com_high;
	assign segment_pins     = st_reg.seg;

endmodule

// >>> lsd_driver_monitor.sv
`timescale 1ns/1ps
module lsd_driver_monitor
	import lsd_pkg::*;
(
	input wire logic                 ref_clk,
	input wire logic                 sys_rst,
	input wire lsd_dm_req_s          dm_req,
	input wire logic [3:0]           dm_rdata,
	input wire lsd_rf_req_s          rf_req,
	input wire logic [3:0]           rf_rdata,
	input wire lsd_pb_req_s          pb_req,
	input wire logic [15:0]          pb_rdata,
	input wire logic                 scan_active,
	input wire logic [1:0]           common_line_low,
	input wire logic [1:0]           common_line_high,
	input wire logic [SEG_LINES-1:0] segment_pins
);
	logic [3:0]  mode_h;
	logic [3:0]  psel_h;
	logic [15:0] scan_h;
	logic [2:0]  q;
	logic        calm;
	// ------------------------------
	// Shadow of written registers
	// ------------------------------
	assign calm = (q > 3'h3);
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			mode_h <= MODE_RESET;
			psel_h <= PSEL_RESET;
			scan_h <= SCAN_RESET;
			q      <= 3'h0;
		end
		else
		begin
			if (rf_req.wr && rf_req.addr == RF_MODE_ADDR)
				mode_h <= rf_req.wdata;
			if (rf_req.wr && rf_req.addr == RF_PORT_ADDR)
				psel_h <= rf_req.wdata;
			if (pb_req.put && pb_req.addr == PB_SCAN_ADDR)
				scan_h <= pb_req.wdata;
			q <= (rf_req.wr || pb_req.put) ? 3'h0 : (q == 3'h7 ? q : q + 3'h1);
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_dm_wr;
		dm_req.wr && !pb_req.put && dm_req.addr != 4'hf ##1 !pb_req.put && $stable(dm_req.addr)
			##1 $stable(dm_req.addr);
	endsequence
	property p_dm_rw;
		s_dm_wr |-> dm_rdata == $past(dm_req.wdata, 2);
	endproperty
	property p_com_off;
		calm && !mode_h[MODE_DISP_BIT] |-> common_line_low == LVL_LOW && common_line_high == LVL_LOW;
	endproperty
	property p_seg_off;
		calm && !mode_h[MODE_DISP_BIT] && psel_h == 4'h0 |-> segment_pins == '0;
	endproperty
	property p_mode_rd;
		rf_req.rd && rf_req.addr == RF_MODE_ADDR |=> rf_rdata == $past(mode_h);
	endproperty
	property p_psel_rd;
		rf_req.rd && rf_req.addr == RF_PORT_ADDR |=> rf_rdata == $past(psel_h);
	endproperty
	property p_scan_rd;
		pb_req.get && pb_req.addr == PB_SCAN_ADDR |=> pb_rdata == $past(scan_h);
	endproperty
	property p_grp_rd;
		pb_req.get && pb_req.addr >= PB_GROUP_BASE && pb_req.addr <= PB_GROUP_LAST |=> pb_rdata == 16'h0000;
	endproperty
	property p_scan_slot;
		calm && scan_active && !psel_h[PSEL_SCAN_BIT] |-> common_line_low == LVL_MID
			&& common_line_high == LVL_MID && segment_pins[15:0] == scan_h;
	endproperty
	property p_disp_slot;
		calm && mode_h[MODE_DISP_BIT] && !scan_active |-> (common_line_low == LVL_MID) != (common_line_high == LVL_MID);
	endproperty
	property p_port_scan;
		calm && psel_h[PSEL_SCAN_BIT] |-> segment_pins[15:0] == scan_h;
	endproperty
	a_dm_rw: assert property (p_dm_rw) else $error("memory nibble not read back");
	a_com_off: assert property (p_com_off) else $error("commons not low when off");
	a_seg_off: assert property (p_seg_off) else $error("segments not low when off");
	a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
	a_psel_rd: assert property (p_psel_rd) else $error("port select readback wrong");
	a_scan_rd: assert property (p_scan_rd) else $error("scan data readback wrong");
	a_grp_rd: assert property (p_grp_rd) else $error("group read not zero");
	a_scan_slot: assert property (p_scan_slot) else $error("scan slot output wrong");
	a_disp_slot: assert property (p_disp_slot) else $error("no single selected common");
	a_port_scan: assert property (p_port_scan) else $error("scan port pins wrong");
endmodule
bind lsd_driver lsd_driver_monitor lsd_driver_monitor_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.dm_req(dm_req), .dm_rdata(dm_rdata), .rf_req(rf_req), .rf_rdata(rf_rdata), .pb_req(pb_req),
	.pb_rdata(pb_rdata), .scan_active(scan_active), .common_line_low(common_line_low),
	.common_line_high(common_line_high), .segment_pins(segment_pins));

// >>> lsd_key_matrix.sv
`timescale 1ns/1ps
module lsd_key_matrix
	import lsd_pkg::*;
(
	input wire logic [SCAN_PINS-1:0]  key_down,
	input wire logic                  scan_active,
	input wire logic [SEG_LINES-1:0]  segment_pins,
	output logic     [KEY_INPUTS-1:0] key_return_inputs
);
	// Returns pulled down outside scan slots
	always_comb
	begin
		for (int r = 0; r < KEY_INPUTS; r++)
			key_return_inputs[r] = scan_active && |(key_down[4*r+:4] & segment_pins[4*r+:4]);
	end
endmodule

// >>> tb_lsd_driver.sv
`timescale 1ns/1ps
module tb_lsd_driver
	import lsd_pkg::*;
;
	typedef struct packed {logic [2:0] k; logic [31:0] e;} lsd_note_s;
	logic        ref_clk;
	logic        sys_rst;
	lsd_dm_req_s dm_req;
	lsd_rf_req_s rf_req;
	lsd_pb_req_s pb_req;
	logic [3:0]  dm_rdata, rf_rdata, key_ret, key_sample, kexp;
	logic [15:0] pb_rdata, key_down, scan_m;
	logic        key_sample_valid, scan_active, go, go_d;
	logic [1:0]  com_lo, com_hi;
	logic [29:0] seg;
	logic [59:0] mem_m;
	logic [31:0] w;
	logic [1:0]  lv;
	int          err_count, cmp_count;
	lsd_note_s   nq[$];
	lsd_driver #(.SLOT_LEN_US(3), .SCAN_LEN_US(2)) lsd_driver_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.dm_req(dm_req), .dm_rdata(dm_rdata), .rf_req(rf_req), .rf_rdata(rf_rdata), .pb_req(pb_req),
		.pb_rdata(pb_rdata), .key_return_inputs(key_ret), .key_sample(key_sample),
		.key_sample_valid(key_sample_valid), .scan_active(scan_active), .common_line_low(com_lo),
		.common_line_high(com_hi), .segment_pins(seg));
	lsd_key_matrix lsd_key_matrix_inst (.key_down(key_down), .scan_active(scan_active), .segment_pins(seg),
		.key_return_inputs(key_ret));
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// ------------------------------
	// Checking and bus tasks
	// ------------------------------
	task automatic print_verdict;
		$display("errors=%0d checks=%0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic note(input logic [2:0] k, input logic [31:0] e);
		nq.push_back(lsd_note_s'{k, e});
		go <= 1'b1;
		@(negedge ref_clk);
		go <= 1'b0;
		rf_req <= '0;
		pb_req <= '0;
	endtask
	task automatic pins(input logic [2:0] k, input logic [31:0] e);
		@(negedge ref_clk);
		note(k, e);
	endtask
	task automatic rfw(input logic [6:0] a, input logic [3:0] d);
		@(negedge ref_clk);
		rf_req <= '{1'b1, 1'b0, a, d};
		@(negedge ref_clk);
		rf_req <= '0;
	endtask
	task automatic rfr(input logic [6:0] a, input logic [3:0] e);
		@(negedge ref_clk);
		rf_req <= '{1'b0, 1'b1, a, 4'h0};
		note(3'h0, e);
	endtask
	task automatic pbw(input logic [7:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		pb_req <= '{1'b1, 1'b0, a, d};
		@(negedge ref_clk);
		pb_req <= '0;
	endtask
	task automatic pbr(input logic [7:0] a, input logic [15:0] e);
		@(negedge ref_clk);
		pb_req <= '{1'b0, 1'b1, a, 16'h0};
		note(3'h1, e);
	endtask
	task automatic dmr(input logic [3:0] a, input logic [3:0] e);
		@(negedge ref_clk);
		dm_req <= '{1'b0, 1'b0, a, 4'h0};
		pins(3'h4, e);
	endtask
	task automatic slot_wait;
		logic [1:0] c;
		c = com_lo;
		for (int t = 0; t < 3000 && com_lo === c; t++)
			@(negedge ref_clk);
		chk({31'h0, com_lo !== c}, 32'h1);
		repeat (5) @(negedge ref_clk);
	endtask
	function automatic logic [29:0] pexp(input logic [3:0] ps);
		logic [29:0] r;
		for (int k = 0; k < 30; k++)
			r[k] = ps[k < 16 ? 0 : k < 22 ? 1 : k < 26 ? 2 : 3] & (k < 16 ? scan_m[k] : mem_m[2*k]);
		return r;
	endfunction
	function automatic logic [29:0] dexp(input logic s, input logic p);
		logic [29:0] r;
		for (int k = 0; k < 30; k++)
			r[k] = p ^ mem_m[2*k+int'(s)];
		return r;
	endfunction
	always @(posedge ref_clk)
		go_d <= go;
	always @(negedge ref_clk)
	begin
		lsd_note_s n;
		if (go_d === 1'b1)
		begin
			n = nq.pop_front();
			case (n.k)
				3'h0: chk({28'h0, rf_rdata}, n.e);
				3'h1: chk({16'h0, pb_rdata}, n.e);
				3'h2: chk({2'h0, seg}, n.e);
				3'h3: chk({28'h0, com_lo, com_hi}, n.e);
				3'h4: chk({28'h0, dm_rdata}, n.e);
				3'h5: chk({28'h0, key_sample}, n.e);
				default: chk({16'h0, seg[15:0]}, n.e);
			endcase
		end
	end
	initial
	begin
		#200000;
		err_count++;
		print_verdict;
	end
	// ------------------------------
	// Scenarios
	// ------------------------------
	initial
	begin
		void'($urandom(32'hf2c11073));
		{sys_rst, dm_req, rf_req, pb_req, go, key_down, mem_m, scan_m} = '0;
		sys_rst = 1'b1;
		err_count = 0;
		cmp_count = 0;
		repeat (6) @(negedge ref_clk);
		sys_rst <= 1'b0;
		rfr(RF_MODE_ADDR, MODE_RESET);
		rfr(RF_PORT_ADDR, PSEL_RESET);
		pbr(PB_SCAN_ADDR, SCAN_RESET);
		pins(3'h3, 32'h0);
		rfw(RF_PORT_ADDR, 4'ha);
		rfr(RF_PORT_ADDR, 4'ha);
		rfw(7'h12, 4'hf);
		rfr(7'h12, 4'h0);
		rfw(RF_MODE_ADDR, 4'h2);
		rfr(RF_MODE_ADDR, 4'h2);
		rfw(RF_MODE_ADDR, 4'h0);
		for (int n = 0; n < 15; n++)
		begin
			w = $urandom;
			@(negedge ref_clk);
			dm_req <= '{1'b1, 1'b0, 4'(n), w[3:0]};
			mem_m[4*n+:4] = w[3:0];
			@(negedge ref_clk);
			dm_req.wr <= 1'b0;
			pins(3'h4, w[3:0]);
		end
		dmr(4'hf, 4'h0);
		for (int g = 0; g < 8; g++)
		begin
			w = $urandom;
			pbw(PB_GROUP_BASE + 8'(g), w[15:0]);
			if (g < 7)
				mem_m[7*g+:7] = w[6:0];
			else
				mem_m[49+:4] = w[3:0];
			pbr(PB_GROUP_BASE + 8'(g), 16'h0);
		end
		for (int n = 0; n < 15; n++)
			dmr(4'(n), mem_m[4*n+:4]);
		scan_m = 16'($urandom);
		pbw(PB_SCAN_ADDR, scan_m);
		pbr(PB_SCAN_ADDR, scan_m);
		pbr(8'h43, 16'h0);
		for (int p = 0; p < 16; p++)
		begin
			rfw(RF_PORT_ADDR, 4'(p));
			repeat (3) @(negedge ref_clk);
			pins(3'h2, {2'h0, pexp(4'(p))});
		end
		rfw(RF_PORT_ADDR, 4'h0);
		rfw(RF_MODE_ADDR, 4'h1);
		for (int i = 0; i < 4; i++)
		begin
			slot_wait();
			lv = (i[1] ^ i[0]) ? LVL_HIGH : LVL_LOW;
			pins(3'h2, {2'h0, dexp(!i[0], i[1] ^ i[0])});
			pins(3'h3, {28'h0, i[0] ? {lv, LVL_MID} : {LVL_MID, lv}});
		end
		key_down = 16'($urandom);
		for (int r = 0; r < 4; r++)
			kexp[r] = |(key_down[4*r+:4] & scan_m[4*r+:4]);
		rfw(RF_MODE_ADDR, 4'h3);
		for (int t = 0; t < 3000 && scan_active !== 1'b1; t++)
			@(negedge ref_clk);
		chk({31'h0, scan_active}, 32'h1);
		pins(3'h6, {16'h0, scan_m});
		for (int t = 0; t < 3000 && key_sample_valid !== 1'b1; t++)
			@(negedge ref_clk);
		chk({31'h0, key_sample_valid}, 32'h1);
		pins(3'h5, {28'h0, kexp});
		rfw(RF_MODE_ADDR, 4'h0);
		repeat (4) @(negedge ref_clk);
		pins(3'h2, 32'h0);
		pins(3'h3, 32'h0);
		repeat (2) @(negedge ref_clk);
		print_verdict;
	end
endmodule
